/* File: hw/esics_map.vh */
// Constants of the sensor command and status block
`ifndef ESICS_MAP_VH
`define ESICS_MAP_VH
`define ESICS_I2C_ADDR      7'h69
`define ESICS_CMD_START     16'h0021
`define ESICS_CMD_START_RHT 16'h0037
`define ESICS_CMD_STOP      16'h0104
`define ESICS_CMD_CLEAN     16'h5607
`define ESICS_CMD_INTERVAL  16'h8004
`define ESICS_CMD_STATUS    16'hd206
`define ESICS_CMD_CLR_STAT  16'hd210
`define ESICS_CMD_RESET     16'hd304
`define ESICS_CRC_POLY      8'h31
`define ESICS_CRC_INIT      8'hff
`define ESICS_CRC_XOROUT    8'h00
`define ESICS_BIT_SPEED     21
`define ESICS_BIT_CLEAN     19
`define ESICS_BIT_GAS       7
`define ESICS_BIT_HUM_TEMP  6
`define ESICS_BIT_LASER     5
`define ESICS_BIT_STALL     4
`define ESICS_DEF_INTERVAL  32'h00093a80
`define ESICS_CLEAN_TIME_S  10
`define ESICS_SETTLE_TIME_S 3
`define ESICS_SYS_CLK_HZ    25000000
`define ESICS_TICK_TIME_S   1
`define ESICS_TICK_CYCLES   (`ESICS_SYS_CLK_HZ * `ESICS_TICK_TIME_S)
`endif

/* File: hw/esics_top.v */
// I2C target with command interpreter, cleaning scheduler and status word
`default_nettype none
`include "esics_map.vh"

module esics_top #(
   parameter TICK_CYCLES = `ESICS_TICK_CYCLES
) (
   input  wire        sys_clk,
   input  wire        nrst,
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output reg         sda_oe,
   input  wire        fan_speed_bad,
   input  wire        fan_rpm_zero,
   input  wire        laser_current_bad,
   input  wire        gas_sensor_fault,
   input  wire        humidity_temp_link_fault,
   output reg         meas_mode,
   output reg         rht_only_mode,
   output reg         fan_on,
   output reg         fan_max,
   output reg         laser_on,
   output reg         meas_update,
   output reg  [31:0] module_health_word
);
   // ----------------------------------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------------------------------
   reg        rst_meta;
   reg        rst_n;
   reg  [6:0] sync1;
   reg  [6:0] sync2;
   reg        scl_d;
   reg        sda_d;
   wire [6:0] raw_in = {humidity_temp_link_fault, gas_sensor_fault, laser_current_bad,
                        fan_rpm_zero, fan_speed_bad, sda_in, scl_in};
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 7'h7f;
         sync2 <= 7'h7f;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         scl_d <= sync2[0];
         sda_d <= sync2[1];
      end
   end
   wire scl      = sync2[0];
   wire sda      = sync2[1];
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire i2c_start = scl & scl_d & sda_d & ~sda;
   wire i2c_stop  = scl & scl_d & ~sda_d & sda;
   assign sda_out = 1'b0;

   // ----------------------------------------------------------------
   // CRC-8 over a 16-bit word
   // ----------------------------------------------------------------
   function [7:0] crc8;
      input [15:0] word;
      integer i;
      reg [7:0] c;
      begin
         c = `ESICS_CRC_INIT ^ word[15:8];
         for (i = 0; i < 16; i = i + 1) begin
            if (i == 8) begin
               c = c ^ word[7:0];
            end
            c = c[7] ? ({c[6:0], 1'b0} ^ `ESICS_CRC_POLY) : {c[6:0], 1'b0};
         end
         crc8 = c ^ `ESICS_CRC_XOROUT;
      end
   endfunction

   // ----------------------------------------------------------------
   // I2C target engine
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_ADDR = 2'd1;
   localparam [1:0] ST_WR   = 2'd2;
   localparam [1:0] ST_RD   = 2'd3;
   reg  [1:0]  st;
   reg  [3:0]  bitcnt;
   reg         ack_ph;
   reg         nack;
   reg  [7:0]  rxsh;
   reg  [7:0]  txsh;
   reg  [3:0]  wcnt;
   reg  [2:0]  ridx;
   reg  [15:0] cmd;
   reg  [15:0] ptr;
   reg  [47:0] rxd;
   reg  [31:0] interval;
   reg         exec;
   reg  [31:0] rd_val;
   reg  [7:0]  tx_byte;
   wire [15:0] rd_word = (ridx < 3'd3) ? rd_val[31:16] : rd_val[15:0];
   always @* begin
      rd_val = 32'h0;
      if (ptr == `ESICS_CMD_INTERVAL) begin
         rd_val = interval;
      end else if (ptr == `ESICS_CMD_STATUS) begin
         rd_val = module_health_word;
      end
      case (ridx)
         3'd0, 3'd3: tx_byte = rd_word[15:8];
         3'd1, 3'd4: tx_byte = rd_word[7:0];
         3'd2, 3'd5: tx_byte = crc8(rd_word);
         default:    tx_byte = 8'hff;
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st     <= ST_IDLE;
         bitcnt <= 4'h0;
         ack_ph <= 1'b0;
         nack   <= 1'b0;
         rxsh   <= 8'h0;
         txsh   <= 8'h0;
         wcnt   <= 4'h0;
         ridx   <= 3'h0;
         cmd    <= 16'h0;
         ptr    <= 16'h0;
         rxd    <= 48'h0;
         exec   <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         exec <= 1'b0;
         if (i2c_start || i2c_stop) begin
            if (st == ST_WR && wcnt >= 4'd2) begin
               ptr  <= cmd;
               exec <= 1'b1;
            end
            st     <= i2c_start ? ST_ADDR : ST_IDLE;
            bitcnt <= 4'h0;
            ack_ph <= 1'b0;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            if (bitcnt < 4'd8) begin
               bitcnt <= bitcnt + 4'd1;
               rxsh   <= {rxsh[6:0], sda};
            end else if (ack_ph) begin
               nack <= sda;
            end
         end else if (scl_fall && st != ST_IDLE) begin
            if (st == ST_RD && bitcnt != 4'd8) begin
               sda_oe <= ~txsh[7];
               txsh   <= {txsh[6:0], 1'b0};
            end else if (!ack_ph && bitcnt == 4'd8) begin
               ack_ph <= 1'b1;
               if (st == ST_ADDR) begin
                  if (rxsh[7:1] == `ESICS_I2C_ADDR) begin
                     sda_oe <= 1'b1;
                     wcnt   <= 4'h0;
                  end else begin
                     st <= ST_IDLE;
                  end
               end else if (st == ST_WR) begin
                  sda_oe <= 1'b1;
                  if (wcnt < 4'd2) begin
                     cmd <= {cmd[7:0], rxsh};
                  end else begin
                     rxd <= {rxd[39:0], rxsh};
                  end
                  if (wcnt != 4'hf) begin
                     wcnt <= wcnt + 4'd1;
                  end
               end else begin
                  sda_oe <= 1'b0;
               end
            end else if (ack_ph) begin
               ack_ph <= 1'b0;
               bitcnt <= 4'h0;
               sda_oe <= 1'b0;
               if ((st == ST_ADDR && rxsh[0]) || (st == ST_RD && !nack)) begin
                  st     <= ST_RD;
                  sda_oe <= ~tx_byte[7];
                  txsh   <= {tx_byte[6:0], 1'b0};
                  ridx   <= (st == ST_ADDR) ? 3'd1 : ridx + 3'd1;
                  if (st == ST_ADDR) begin
                     sda_oe <= ~rd_val[31];
                     txsh   <= {rd_val[30:24], 1'b0};
                  end
               end else if (st == ST_ADDR) begin
                  st <= ST_WR;
               end else if (st == ST_RD) begin
                  st <= ST_IDLE;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   wire short_cmd  = exec && (wcnt == 4'd2);
   wire do_start   = short_cmd && (cmd == `ESICS_CMD_START);
   wire do_rht     = short_cmd && (cmd == `ESICS_CMD_START_RHT);
   wire do_stop    = short_cmd && (cmd == `ESICS_CMD_STOP);
   wire do_clean   = short_cmd && (cmd == `ESICS_CMD_CLEAN) && meas_mode;
   wire do_clear   = short_cmd && (cmd == `ESICS_CMD_CLR_STAT);
   wire do_reset   = short_cmd && (cmd == `ESICS_CMD_RESET);
   wire crc_ok     = (crc8(rxd[47:32]) == rxd[31:24]) && (crc8(rxd[23:8]) == rxd[7:0]);
   wire do_set_int = exec && (wcnt == 4'd8) && (cmd == `ESICS_CMD_INTERVAL) && crc_ok;

   // ----------------------------------------------------------------
   // Second tick, cleaning scheduler and fan checks
   // ----------------------------------------------------------------
   reg  [31:0] tick_cnt;
   reg         tick;
   reg  [31:0] elapsed;
   reg  [3:0]  clean_secs;
   reg         cleaning;
   reg  [1:0]  settle;
   reg         speed_miss;
   reg         zero_miss;
   reg         speed_flag;
   reg         stall_flag;
   reg         laser_flag;
   reg         gas_flag;
   reg         ht_flag;
   wire        checks_on = meas_mode && tick && !cleaning
                           && (settle == `ESICS_SETTLE_TIME_S);
   wire        auto_due  = meas_mode && tick && !cleaning && (interval != 32'h0)
                           && (elapsed + 32'd1 >= interval);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt      <= 32'h0;
         tick          <= 1'b0;
         elapsed       <= 32'h0;
         interval      <= `ESICS_DEF_INTERVAL;
         clean_secs    <= 4'h0;
         cleaning      <= 1'b0;
         settle        <= 2'h0;
         meas_mode     <= 1'b0;
         rht_only_mode <= 1'b0;
         speed_miss    <= 1'b0;
         zero_miss     <= 1'b0;
         speed_flag    <= 1'b0;
         stall_flag    <= 1'b0;
         laser_flag    <= 1'b0;
         gas_flag      <= 1'b0;
         ht_flag       <= 1'b0;
      end else begin
         tick     <= (tick_cnt == TICK_CYCLES - 1);
         tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'd1;
         if (do_start || do_rht || do_stop || do_reset) begin
            meas_mode     <= do_start;
            rht_only_mode <= do_rht;
            cleaning      <= 1'b0;
            settle        <= 2'h0;
            speed_miss    <= 1'b0;
            zero_miss     <= 1'b0;
         end
         if (do_reset) begin
            interval <= `ESICS_DEF_INTERVAL;
         end else if (do_set_int) begin
            interval <= {rxd[47:32], rxd[23:8]};
         end
         if (meas_mode && tick && settle != `ESICS_SETTLE_TIME_S) begin
            settle <= settle + 2'd1;
         end
         if (meas_mode && tick && !cleaning) begin
            elapsed <= elapsed + 32'd1;
         end
         if (do_clean || auto_due) begin
            cleaning   <= 1'b1;
            clean_secs <= 4'h0;
            elapsed    <= 32'h0;
         end else if (cleaning && tick) begin
            clean_secs <= clean_secs + 4'd1;
            if (clean_secs == `ESICS_CLEAN_TIME_S - 1) begin
               cleaning <= 1'b0;
               elapsed  <= 32'h0;
            end
         end
         if (do_clear || do_reset) begin
            speed_flag <= 1'b0;
            stall_flag <= 1'b0;
            laser_flag <= 1'b0;
            gas_flag   <= 1'b0;
            ht_flag    <= 1'b0;
         end
         if (checks_on) begin
            speed_miss <= sync2[2];
            zero_miss  <= sync2[3];
            if (sync2[2] && speed_miss) begin
               speed_flag <= 1'b1;
            end else if (!sync2[2]) begin
               speed_flag <= 1'b0;
            end
            if (sync2[3] && zero_miss) begin
               stall_flag <= 1'b1;
            end
         end
         if (meas_mode && tick && sync2[4]) begin
            laser_flag <= 1'b1;
         end
         if ((meas_mode || rht_only_mode) && sync2[5]) begin
            gas_flag <= 1'b1;
         end
         if ((meas_mode || rht_only_mode) && sync2[6]) begin
            ht_flag <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs and status word
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fan_on             <= 1'b0;
         fan_max            <= 1'b0;
         laser_on           <= 1'b0;
         meas_update        <= 1'b0;
         module_health_word <= 32'h0;
      end else begin
         fan_on      <= meas_mode;
         fan_max     <= cleaning;
         laser_on    <= meas_mode;
         meas_update <= (meas_mode || rht_only_mode) && tick && !cleaning;
         module_health_word                      <= 32'h0;
         module_health_word[`ESICS_BIT_SPEED]    <= speed_flag;
         module_health_word[`ESICS_BIT_CLEAN]    <= cleaning;
         module_health_word[`ESICS_BIT_GAS]      <= gas_flag;
         module_health_word[`ESICS_BIT_HUM_TEMP] <= ht_flag;
         module_health_word[`ESICS_BIT_LASER]    <= laser_flag;
         module_health_word[`ESICS_BIT_STALL]    <= stall_flag;
      end
   end
endmodule
`default_nettype wire

/* File: tb/esics_properties.sv */
// Port checks of the sensor command and status block
`default_nettype none
module esics_properties #(
   parameter TICK_CYCLES = 50
) (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        meas_mode,
   input wire logic        fan_on,
   input wire logic        fan_max,
   input wire logic        laser_on,
   input wire logic        meas_update,
   input wire logic [31:0] module_health_word
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = TICK_CYCLES;
   int run_len;
   int meas_len;
   // -----------------------------
   // Run and measurement lengths
   // -----------------------------
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         run_len <= 0;
         meas_len <= 0;
      end else begin
         run_len <= fan_max ? run_len + 1 : 0;
         meas_len <= meas_mode ? meas_len + 1 : 0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_sda_low_only: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   a_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("sda moved while scl high");
   a_clean_flag: assert property ($rose(fan_max) |-> ##[0:2] module_health_word[19])
      else $error("clean flag missing");
   a_clean_length: assert property ($fell(fan_max) ##1 meas_mode |->
      $past(run_len) >= 9 * TK && $past(run_len) <= 10 * TK + 2)
      else $error("clean run length wrong");
   a_freeze_update: assert property (fan_max && $past(fan_max) |-> !meas_update)
      else $error("update during cleaning");
   a_idle_off: assert property (!meas_mode ##1 !meas_mode |-> !fan_on && !laser_on)
      else $error("fan or laser on in idle");
   a_clean_in_meas: assert property (fan_max |-> meas_mode || $past(meas_mode))
      else $error("cleaning outside measurement");
   a_laser_sticky: assert property ($fell(module_health_word[5]) |-> scl_in && sda_in)
      else $error("laser flag self-cleared");
   a_stall_sticky: assert property ($fell(module_health_word[4]) |-> scl_in && sda_in)
      else $error("stall flag self-cleared");
   a_speed_settle: assert property ($rose(module_health_word[21]) |-> meas_len > 3 * TK)
      else $error("speed flag during settling");
endmodule
`default_nettype wire

/* File: tb/esics_host.sv */
// I2C bus controller model facing the sensor block
`default_nettype none
`include "esics_map.vh"
module esics_host (
   input  wire logic sys_clk,
   input  wire logic sda_oe,
   output var  logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pull = 1'b0;
   int   nak = 0;
   // Interface strap is held low from power-up, so only this link exists
   // Open drain with pull-up, clock never released to the block
   assign sda = ~(pull | sda_oe);
   initial scl = 1'b1;
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      wt(1);
      pull = ~b;
      wt(3);
      scl = 1'b1;
      wt(2);
      r = sda;
      wt(2);
      scl = 1'b0;
   endtask
   // Start when first is 0, stop when 1
   task automatic cond(input logic first);
      wt(1);
      pull = first;
      wt(3);
      scl = 1'b1;
      wt(4);
      pull = ~first;
      if (!first) begin
         wt(4);
         scl = 1'b0;
      end
   endtask
   task automatic wr_byte(input logic [7:0] b);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(b[i], a);
      bit_io(1'b1, a);
      nak += int'(a);
   endtask
   task automatic rd_byte(input logic last, output logic [7:0] v);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(last, a);
   endtask
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      return c;
   endfunction
   // Command code bare, each data word with its checksum
   task automatic write(input logic [6:0] adr, input logic [15:0] cmd, input int nw,
                        input logic [31:0] d, input logic [7:0] flip);
      cond(1'b0);
      wr_byte({adr, 1'b0});
      wr_byte(cmd[15:8]);
      wr_byte(cmd[7:0]);
      for (int k = nw - 1; k >= 0; k--) begin
         wr_byte(d[16*k+8 +: 8]);
         wr_byte(d[16*k +: 8]);
         wr_byte(crc8(d[16*k +: 16]) ^ flip);
      end
      cond(1'b1);
      wt(8);
   endtask
   task automatic read(input logic [15:0] cmd, output logic [31:0] d, output int bad);
      logic [7:0] h;
      logic [7:0] l;
      logic [7:0] c;
      write(`ESICS_I2C_ADDR, cmd, 0, 32'h0, 8'h00);
      cond(1'b0);
      wr_byte({`ESICS_I2C_ADDR, 1'b1});
      bad = 0;
      for (int k = 1; k >= 0; k--) begin
         rd_byte(1'b0, h);
         rd_byte(1'b0, l);
         rd_byte(k == 0, c);
         d[16*k +: 16] = {h, l};
         bad += int'(c !== crc8({h, l}));
      end
      cond(1'b1);
      wt(8);
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the sensor command and status block
`default_nettype none
`include "esics_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 50;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [4:0]  flt = 5'h00;
   wire         scl;
   wire         sda;
   wire         sda_out;
   wire         sda_oe;
   wire  [5:0]  mo;
   wire  [31:0] hw;
   int          err_count = 0;
   int          cmp_count = 0;
   int          nb;
   int          upd;
   int          bad;
   logic [31:0] rd;
   logic [31:0] v;
   logic [31:0] exp_int;
   always #20 sys_clk = ~sys_clk;
   esics_top #(.TICK_CYCLES(TK)) i_dut (
      .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .fan_speed_bad(flt[0]), .fan_rpm_zero(flt[1]),
      .laser_current_bad(flt[2]), .gas_sensor_fault(flt[3]),
      .humidity_temp_link_fault(flt[4]), .meas_mode(mo[5]), .rht_only_mode(mo[4]),
      .fan_on(mo[3]), .fan_max(mo[2]), .laser_on(mo[1]), .meas_update(mo[0]),
      .module_health_word(hw));
   esics_host i_host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cmd(input logic [15:0] c);
      i_host.write(`ESICS_I2C_ADDR, c, 0, 32'h0, 8'h00);
   endtask
   task automatic wr_int(input logic [31:0] d, input logic [7:0] flip);
      i_host.write(`ESICS_I2C_ADDR, `ESICS_CMD_INTERVAL, 2, d, flip);
   endtask
   // Waits for the cleaning output to reach lvl, counting updates
   task automatic watch(input logic lvl, input int lim, input bit must);
      nb = 0;
      upd = 0;
      while (mo[2] !== lvl && nb < lim) begin
         @(negedge sys_clk);
         nb++;
         upd += int'(mo[0] === 1'b1);
      end
      if (must && nb == lim) begin
         err_count++;
         final_report;
      end
   endtask
   initial begin
      void'($urandom(19473));
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (6) @(negedge sys_clk);
      check(32'(mo), 32'h0);
      check(32'(i_host.crc8(16'hbeef)), 32'h92);
      exp_int = `ESICS_DEF_INTERVAL;
      v = $urandom | 32'h1;
      for (int i = 0; i < 3; i++) begin
         if (i > 0) wr_int(v, i == 1 ? 8'h01 : 8'h00);
         if (i == 2) exp_int = v;
         i_host.read(`ESICS_CMD_INTERVAL, rd, bad);
         check(rd, exp_int);
         check(bad, 0);
      end
      $display("test interval access done");
      i_host.write(`ESICS_I2C_ADDR ^ 7'h01, `ESICS_CMD_START, 0, 32'h0, 8'h00);
      check(i_host.nak, 3);
      cmd(`ESICS_CMD_CLEAN);
      check(32'(mo), 32'h0);
      cmd(`ESICS_CMD_START_RHT);
      cmd(`ESICS_CMD_CLEAN);
      check(32'(mo[5:2]), 32'h4);
      $display("test refusals done");
      wr_int(32'h3, 8'h00);
      cmd(`ESICS_CMD_START);
      check(32'(mo[5:1]), 32'h15);
      for (int i = 0; i < 2; i++) begin
         watch(1'b1, 4 * TK, 1'b1);
         check(32'(nb > 2 * TK - 20 && nb <= 3 * TK + 2), 32'h1);
         repeat (3) @(negedge sys_clk);
         check(32'(hw[19]), 32'h1);
         watch(1'b0, 11 * TK, 1'b1);
         check(32'(nb >= 9 * TK - 5 && nb <= 10 * TK + 2), 32'h1);
         check(upd, 0);
      end
      wr_int(32'h0, 8'h00);
      watch(1'b0, 11 * TK, 1'b1);
      watch(1'b1, 6 * TK, 1'b0);
      check(nb, 6 * TK);
      check(upd, 6);
      $display("test cleaning schedule done");
      flt = 5'h1f;
      repeat (3 * TK) @(negedge sys_clk);
      i_host.read(`ESICS_CMD_STATUS, rd, bad);
      check(rd, 32'h002000f0);
      flt = 5'h00;
      repeat (3 * TK) @(negedge sys_clk);
      i_host.read(`ESICS_CMD_STATUS, rd, bad);
      check(rd, 32'h000000f0);
      cmd(`ESICS_CMD_CLR_STAT);
      i_host.read(`ESICS_CMD_STATUS, rd, bad);
      check(rd, 32'h0);
      $display("test status word done");
      for (int i = 0; i < 2; i++) begin
         wr_int(32'h00010007, 8'h00);
         cmd(`ESICS_CMD_START);
         if (i == 0) begin
            cmd(`ESICS_CMD_RESET);
         end else begin
            nrst = 1'b0;
            repeat (2) @(negedge sys_clk);
            nrst = 1'b1;
            repeat (6) @(negedge sys_clk);
         end
         check(32'(mo[5:1]), 32'h0);
         i_host.read(`ESICS_CMD_INTERVAL, rd, bad);
         check(rd, `ESICS_DEF_INTERVAL);
      end
      cmd(`ESICS_CMD_START_RHT);
      cmd(`ESICS_CMD_STOP);
      check(32'(mo[5:1]), 32'h0);
      $display("test resets done");
      final_report;
   end
endmodule
bind esics_top esics_properties #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
   .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .meas_mode(meas_mode), .fan_on(fan_on), .fan_max(fan_max),
   .laser_on(laser_on), .meas_update(meas_update),
   .module_health_word(module_health_word));
`default_nettype wire
